// ===== verilog/lsfr_pkg.sv
// Constants for the load status and fault register bank.
// Assumes a 32-bit APB slave with 16-bit byte addresses.
`default_nettype none
package lsfr_pkg;
  // ----------------------------------------------------------
  // Bus and register map (index, byte address is index times 4)
  // ----------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] IDX_FAULT_SUM = 16'h200b;
  localparam logic [15:0] IDX_OP_LO = 16'h200d;
  localparam logic [15:0] IDX_LATCH_REL = 16'h200e;
  localparam logic [15:0] IDX_IN_EN = 16'h2011;
  localparam logic [15:0] IDX_OP_HI = 16'h2020;
  localparam logic [15:0] IDX_START = 16'h2021;
  localparam logic [15:0] ADDR_FAULT_SUM = {IDX_FAULT_SUM[13:0], 2'h0};
  localparam logic [15:0] ADDR_OP_LO = {IDX_OP_LO[13:0], 2'h0};
  localparam logic [15:0] ADDR_LATCH_REL = {IDX_LATCH_REL[13:0], 2'h0};
  localparam logic [15:0] ADDR_IN_EN = {IDX_IN_EN[13:0], 2'h0};
  localparam logic [15:0] ADDR_OP_HI = {IDX_OP_HI[13:0], 2'h0};
  localparam logic [15:0] ADDR_START = {IDX_START[13:0], 2'h0};
  localparam logic RST_IN_EN = 1'h0;
  localparam logic RST_LATCH = 1'h0;
  // ----------------------------------------------------------
  // Raw condition input positions
  // ----------------------------------------------------------
  localparam int COND_W = 18;
  localparam int C_SOCT = 0;
  localparam int C_SOVT = 1;
  localparam int C_SOPT = 2;
  localparam int C_UVT = 3;
  localparam int C_SENSE_OOB = 4;
  localparam int C_TCUR = 5;
  localparam int C_TVOLT = 6;
  localparam int C_LIN_OT = 7;
  localparam int C_RES_OT = 8;
  localparam int C_REG = 9;
  localparam int C_BOOT_FAIL = 13;
  localparam int C_BOOT_WAIT = 14;
  localparam int C_UNDER_MIN = 15;
  localparam int C_REG_LOSS = 16;
  localparam int C_SENSE_USE = 17;
  localparam int REG_W = 4;
  // ----------------------------------------------------------
  // Fault summary word fields
  // ----------------------------------------------------------
  localparam int FAULT_W = 13;
  localparam int FB_HOVP = 0;
  localparam int FB_STRIP = 1;
  localparam int FB_HOCP = 4;
  localparam int FB_HOTP = 5;
  localparam int FB_SENSE_LOSS = 6;
  localparam int FB_CONST = 7;
  localparam int FB_ANY_SOFT = 11;
  localparam int FB_ANY_HARD = 12;
  localparam int SOFT_N = 3;
  // ----------------------------------------------------------
  // Operation status word fields
  // ----------------------------------------------------------
  localparam int OP_W = 64;
  localparam int OB_STANDBY = 0;
  localparam int OB_ACTIVE = 1;
  localparam int OB_TRIP = 4;
  localparam int OB_SOOB = 7;
  localparam int OB_UVT = 8;
  localparam int OB_BFAIL = 12;
  localparam int OB_BWAIT = 13;
  localparam int OB_TCUR = 16;
  localparam int OB_TVOLT = 17;
  localparam int OB_LIN_OT = 18;
  localparam int OB_RES_OT = 27;
  localparam int OB_UMIN = 28;
  localparam int OB_RLOSS = 29;
  localparam int OB_CONST = 32;
  localparam int OB_SENSE = 37;
  localparam int OB_OTEMP = 40;
  localparam int OB_SSHUT = 41;
  localparam int OB_HSHUT = 42;
  localparam int OB_USED = 43;
  // Input state, one-hot
  typedef enum logic [1:0] {
    ST_STANDBY = 2'h1,
    ST_ACTIVE = 2'h2
  } lsfr_in_state_type;
endpackage
`default_nettype wire

// ===== verilog/lsfr_cond_if.sv
// Carrier for raw and cleaned condition levels.
// Assumes one clock domain on the cleaned side.
`timescale 1ns/1ps
`default_nettype none
interface lsfr_cond_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// ===== verilog/lsfr_cond_sync.sv
// Three-stage synchroniser for asynchronous condition levels.
// Assumes levels change far slower than pclk.
`timescale 1ns/1ps
`default_nettype none
module lsfr_cond_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  lsfr_cond_if.sync cif
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] clean_ff;
  logic [W-1:0] agree;
  logic [W-1:0] nxt_clean;

  // A change counts once stages two and three agree
  assign agree = ~(s2_ff ^ s3_ff);
  assign nxt_clean = (agree & s3_ff) | (~agree & clean_ff);
  assign cif.clean = clean_ff;

  // Sampling chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      clean_ff <= '0;
    end
    else
    begin
      s1_ff <= cif.raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      clean_ff <= nxt_clean;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/lsfr_top.sv
// Status, fault summary and input control register bank of a load.
// Assumes condition levels arrive asynchronously on cond_raw and
// software reaches the registers over APB with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module lsfr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lsfr_pkg::ADDR_W-1:0] paddr,
  input wire logic [lsfr_pkg::DATA_W-1:0] pwdata,
  output logic [lsfr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [lsfr_pkg::COND_W-1:0] cond_raw,
  output logic load_input_on,
  output logic load_input_hiz
);
  // ----------------------------------------------------------
  // Condition synchroniser
  // ----------------------------------------------------------
  lsfr_cond_if #(.W(lsfr_pkg::COND_W)) cif ();
  assign cif.raw = cond_raw;

  lsfr_cond_sync #(.W(lsfr_pkg::COND_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .cif(cif)
  );

  logic [lsfr_pkg::COND_W-1:0] c;
  assign c = cif.clean;

  // ----------------------------------------------------------
  // Fault classification
  // ----------------------------------------------------------
  logic soft_overcurrent_trip;
  logic soft_overvoltage_trip;
  logic soft_overpower_trip;
  logic hard_overvoltage_fault;
  logic hard_overcurrent_fault;
  logic hard_otp;
  logic sense_loss_fault;
  logic any_soft_fault;
  logic any_hard_fault;
  logic soft_cause;
  logic fault_now;

  // Trip and protection levels feeding both words
  assign soft_overcurrent_trip = c[lsfr_pkg::C_SOCT];
  assign soft_overvoltage_trip = c[lsfr_pkg::C_SOVT];
  assign soft_overpower_trip = c[lsfr_pkg::C_SOPT];
  assign hard_overvoltage_fault = c[lsfr_pkg::C_TVOLT];
  assign hard_overcurrent_fault = c[lsfr_pkg::C_TCUR];
  assign hard_otp = c[lsfr_pkg::C_LIN_OT] | c[lsfr_pkg::C_RES_OT];
  assign sense_loss_fault = c[lsfr_pkg::C_SENSE_OOB];
  assign any_soft_fault = soft_overcurrent_trip | soft_overvoltage_trip |
                          soft_overpower_trip;
  assign any_hard_fault = hard_overvoltage_fault | hard_overcurrent_fault |
                          hard_otp | sense_loss_fault;
  // Under-voltage trips also shut down as a soft cause
  assign soft_cause = any_soft_fault | c[lsfr_pkg::C_UVT];
  assign fault_now = soft_cause | any_hard_fault;

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  logic rd_setup;
  logic wr_done;
  logic hit_fault;
  logic hit_op_lo;
  logic hit_op_hi;
  logic hit_latch;
  logic hit_in_en;
  logic hit_start;
  logic hit_any;
  logic rel_req;
  logic rel_ok;
  logic start_req;
  logic in_en_wr;

  // Address match and strobes
  assign hit_fault = paddr == lsfr_pkg::ADDR_FAULT_SUM;
  assign hit_op_lo = paddr == lsfr_pkg::ADDR_OP_LO;
  assign hit_op_hi = paddr == lsfr_pkg::ADDR_OP_HI;
  assign hit_latch = paddr == lsfr_pkg::ADDR_LATCH_REL;
  assign hit_in_en = paddr == lsfr_pkg::ADDR_IN_EN;
  assign hit_start = paddr == lsfr_pkg::ADDR_START;
  assign hit_any = hit_fault | hit_op_lo | hit_op_hi | hit_latch |
                   hit_in_en | hit_start;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_done = psel & penable & pwrite & pready;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign rel_req = wr_done & hit_latch & pwdata[0];
  assign rel_ok = rel_req & ~fault_now;
  assign start_req = wr_done & hit_start & pwdata[0];
  assign in_en_wr = wr_done & hit_in_en;

  // ----------------------------------------------------------
  // Fault latch and shutdown causes
  // ----------------------------------------------------------
  logic latch_ff;
  logic sshut_ff;
  logic hshut_ff;
  logic in_en_ff;
  logic nxt_latch;
  logic nxt_sshut;
  logic nxt_hshut;
  logic nxt_in_en;

  // A fault in the release cycle wins over the release
  assign nxt_latch = fault_now ? 1'b1 : (rel_ok ? 1'b0 : latch_ff);
  assign nxt_sshut = soft_cause ? 1'b1 : (rel_ok ? 1'b0 : sshut_ff);
  assign nxt_hshut = any_hard_fault ? 1'b1 : (rel_ok ? 1'b0 : hshut_ff);
  assign nxt_in_en = in_en_wr ? pwdata[0] : in_en_ff;

  // Latch, causes and enable flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_ff <= lsfr_pkg::RST_LATCH;
      sshut_ff <= lsfr_pkg::RST_LATCH;
      hshut_ff <= lsfr_pkg::RST_LATCH;
      in_en_ff <= lsfr_pkg::RST_IN_EN;
    end
    else
    begin
      latch_ff <= nxt_latch;
      sshut_ff <= nxt_sshut;
      hshut_ff <= nxt_hshut;
      in_en_ff <= nxt_in_en;
    end
  end

  // ----------------------------------------------------------
  // Input state
  // ----------------------------------------------------------
  lsfr_pkg::lsfr_in_state_type state_ff;
  lsfr_pkg::lsfr_in_state_type nxt_state;
  logic start_ok;
  logic stop_now;

  // Only a start command brings the input back after release
  assign start_ok = start_req & in_en_ff & ~latch_ff & ~fault_now;
  assign stop_now = ~in_en_ff | latch_ff | fault_now;

  // Standby and active sequencing
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      lsfr_pkg::ST_STANDBY:
      begin
        if (start_ok)
          nxt_state = lsfr_pkg::ST_ACTIVE;
      end
      lsfr_pkg::ST_ACTIVE:
      begin
        if (stop_now)
          nxt_state = lsfr_pkg::ST_STANDBY;
      end
      default:
        nxt_state = lsfr_pkg::ST_STANDBY;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= lsfr_pkg::ST_STANDBY;
    else
      state_ff <= nxt_state;
  end

  // Disabled input is presented as high impedance
  assign load_input_on = state_ff == lsfr_pkg::ST_ACTIVE;
  assign load_input_hiz = ~load_input_on;

  // ----------------------------------------------------------
  // Status words, live except the latched shutdown causes
  // ----------------------------------------------------------
  logic [lsfr_pkg::FAULT_W-1:0] fault_w;
  logic [lsfr_pkg::OP_W-1:0] op_w;

  // Fault summary assembly, unused bits zero
  always_comb
  begin
    fault_w = '0;
    fault_w[lsfr_pkg::FB_HOVP] = hard_overvoltage_fault;
    fault_w[lsfr_pkg::FB_STRIP +: lsfr_pkg::SOFT_N] =
      {soft_overpower_trip, soft_overvoltage_trip, soft_overcurrent_trip};
    fault_w[lsfr_pkg::FB_HOCP] = hard_overcurrent_fault;
    fault_w[lsfr_pkg::FB_HOTP] = hard_otp;
    fault_w[lsfr_pkg::FB_SENSE_LOSS] = sense_loss_fault;
    fault_w[lsfr_pkg::FB_CONST +: lsfr_pkg::REG_W] =
      c[lsfr_pkg::C_REG +: lsfr_pkg::REG_W];
    fault_w[lsfr_pkg::FB_ANY_SOFT] = any_soft_fault;
    fault_w[lsfr_pkg::FB_ANY_HARD] = any_hard_fault;
  end

  // Operation status assembly, shared fields from the same sources as the summary
  always_comb
  begin
    op_w = '0;
    op_w[lsfr_pkg::OB_STANDBY] = ~load_input_on;
    op_w[lsfr_pkg::OB_ACTIVE] = load_input_on;
    op_w[lsfr_pkg::OB_TRIP +: lsfr_pkg::SOFT_N] =
      {soft_overpower_trip, soft_overvoltage_trip, soft_overcurrent_trip};
    op_w[lsfr_pkg::OB_SOOB] = sense_loss_fault;
    op_w[lsfr_pkg::OB_UVT] = c[lsfr_pkg::C_UVT];
    op_w[lsfr_pkg::OB_BFAIL] = c[lsfr_pkg::C_BOOT_FAIL];
    op_w[lsfr_pkg::OB_BWAIT] = c[lsfr_pkg::C_BOOT_WAIT];
    op_w[lsfr_pkg::OB_TCUR] = hard_overcurrent_fault;
    op_w[lsfr_pkg::OB_TVOLT] = hard_overvoltage_fault;
    op_w[lsfr_pkg::OB_LIN_OT] = c[lsfr_pkg::C_LIN_OT];
    op_w[lsfr_pkg::OB_RES_OT] = c[lsfr_pkg::C_RES_OT];
    op_w[lsfr_pkg::OB_UMIN] = c[lsfr_pkg::C_UNDER_MIN];
    op_w[lsfr_pkg::OB_RLOSS] = c[lsfr_pkg::C_REG_LOSS];
    op_w[lsfr_pkg::OB_CONST +: lsfr_pkg::REG_W] =
      c[lsfr_pkg::C_REG +: lsfr_pkg::REG_W];
    op_w[lsfr_pkg::OB_SENSE] = c[lsfr_pkg::C_SENSE_USE];
    op_w[lsfr_pkg::OB_OTEMP] = hard_otp;
    op_w[lsfr_pkg::OB_SSHUT] = sshut_ff;
    op_w[lsfr_pkg::OB_HSHUT] = hshut_ff;
  end

  // ----------------------------------------------------------
  // Read data
  // ----------------------------------------------------------
  logic [lsfr_pkg::DATA_W-1:0] rd_mux;
  logic [lsfr_pkg::DATA_W-1:0] prdata_ff;

  // Read selection; reads have no side effect on any state
  assign rd_mux =
    hit_fault ? {{(lsfr_pkg::DATA_W - lsfr_pkg::FAULT_W){1'b0}},
                 fault_w} :
    hit_op_lo ? op_w[lsfr_pkg::DATA_W-1:0] :
    hit_op_hi ? op_w[lsfr_pkg::OP_W-1:lsfr_pkg::DATA_W] :
    hit_latch ? {{(lsfr_pkg::DATA_W - 1){1'b0}}, latch_ff} :
    hit_in_en ? {{(lsfr_pkg::DATA_W - 1){1'b0}}, in_en_ff} :
    '0;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= '0;
    else if (rd_setup)
      prdata_ff <= rd_mux;
  end

  assign prdata = prdata_ff;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_soft_or;
    rd_setup && hit_fault |=> prdata_ff[lsfr_pkg::FB_ANY_SOFT] ==
      (|prdata_ff[lsfr_pkg::FB_STRIP +: lsfr_pkg::SOFT_N]);
  endproperty
  a_soft_or: assert property (p_soft_or)
    else $error("soft fault summary bit wrong");

  property p_hard_or;
    rd_setup && hit_fault |=> prdata_ff[lsfr_pkg::FB_ANY_HARD] ==
      (prdata_ff[lsfr_pkg::FB_HOVP] | prdata_ff[lsfr_pkg::FB_HOCP] |
       prdata_ff[lsfr_pkg::FB_HOTP] | prdata_ff[lsfr_pkg::FB_SENSE_LOSS]);
  endproperty
  a_hard_or: assert property (p_hard_or)
    else $error("hard fault summary bit wrong");

  property p_subset;
    fault_w[lsfr_pkg::FB_STRIP +: lsfr_pkg::SOFT_N] ==
      op_w[lsfr_pkg::OB_TRIP +: lsfr_pkg::SOFT_N] &&
    fault_w[lsfr_pkg::FB_CONST +: lsfr_pkg::REG_W] ==
      op_w[lsfr_pkg::OB_CONST +: lsfr_pkg::REG_W] &&
    fault_w[lsfr_pkg::FB_HOVP] == op_w[lsfr_pkg::OB_TVOLT];
  endproperty
  a_subset: assert property (p_subset)
    else $error("fault summary differs from status word");

  property p_standby;
    op_w[lsfr_pkg::OB_STANDBY] == load_input_hiz &&
    op_w[lsfr_pkg::OB_ACTIVE] == load_input_on;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby or active bit wrong");

  property p_fault_latches;
    fault_now |=> latch_ff && !load_input_on;
  endproperty
  a_fault_latches: assert property (p_fault_latches)
    else $error("fault did not latch or disable input");

  property p_latch_holds;
    latch_ff && fault_now |=> latch_ff;
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("latch released while fault present");

  property p_release;
    rel_req && !fault_now && latch_ff |=> !latch_ff;
  endproperty
  a_release: assert property (p_release)
    else $error("release write did not clear latch");

  property p_no_auto_start;
    $fell(latch_ff) |-> !load_input_on;
  endproperty
  a_no_auto_start: assert property (p_no_auto_start)
    else $error("input came on without a start");

  property p_disable;
    in_en_wr && !pwdata[0] |-> ##2 load_input_hiz;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disabled input not high impedance");

  property p_unused_zero;
    rd_setup && hit_op_hi |=>
      prdata_ff[lsfr_pkg::DATA_W-1:lsfr_pkg::OB_USED-lsfr_pkg::DATA_W]
      == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused status bits not zero");

  property p_soft_shut;
    soft_cause |=> op_w[lsfr_pkg::OB_SSHUT];
  endproperty
  a_soft_shut: assert property (p_soft_shut)
    else $error("soft shutdown flag missing");
endmodule
`default_nettype wire

// ===== tb/lsfr_host_model.sv
// APB host model that reads and writes the register bank.
// Assumes one pclk domain; the bench calls xfer for each transfer.
`timescale 1ns/1ps
`default_nettype none
module lsfr_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [lsfr_pkg::ADDR_W-1:0] paddr,
  output logic [lsfr_pkg::DATA_W-1:0] pwdata,
  input wire logic [lsfr_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // --------------------------------------------------------
  // Idle bus and transfer task
  // --------------------------------------------------------
  // Bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
  end

  // Setup, access until pready, then drop psel and penable and invert address and data
  task automatic xfer(input logic w, input logic [15:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench watchdog ends a wait for pready
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;  // No stale address after release
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_load_status_fault_registers.sv
// Self-checking bench for the load status and fault register bank.
// Assumes lsfr_top with zero wait APB and a 3-4 cycle condition sync.
`timescale 1ns/1ps
`default_nettype none
module tb_load_status_fault_registers;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [17:0] cond_raw;
  logic load_input_on;
  logic load_input_hiz;
  int err_count;
  int num_checks;

  lsfr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cond_raw(cond_raw), .load_input_on(load_input_on),
    .load_input_hiz(load_input_hiz));
  lsfr_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // --------------------------------------------------------
  // Expected words and compare helpers
  // --------------------------------------------------------
  function automatic logic [31:0] e_fs(input logic [17:0] c);
    logic [31:0] f;
    f = 32'h0;
    f[0] = c[6];
    f[3:1] = c[2:0];
    f[4] = c[5];
    f[5] = c[7] | c[8];
    f[6] = c[4];
    f[10:7] = c[12:9];
    f[11] = |c[2:0];
    f[12] = |c[8:4];
    return f;
  endfunction

  function automatic logic [31:0] e_lo(input logic [17:0] c, input logic on);
    logic [31:0] l;
    l = 32'h0;
    l[0] = !on;
    l[1] = on;
    l[6:4] = c[2:0];
    l[7] = c[4];
    l[8] = c[3];
    l[13:12] = c[14:13];
    l[16] = c[5];
    l[17] = c[6];
    l[18] = c[7];
    l[27] = c[8];
    l[29:28] = c[16:15];
    return l;
  endfunction

  function automatic logic [31:0] e_hi(input logic [17:0] c, input logic ss,
    input logic hs);
    logic [31:0] h;
    h = 32'h0;
    h[3:0] = c[12:9];
    h[5] = c[17];
    h[8] = c[7] | c[8];
    h[9] = ss;
    h[10] = hs;
    return h;
  endfunction

  task automatic chk32(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e,
    input string nm);
    logic [31:0] d;
    logic er;
    host.xfer(1'b0, a, 32'h0, d, er);
    chk1("pslverr", 1'b0, er);
    chk32(nm, e, d);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    host.xfer(1'b1, a, d, q, er);
    chk1("pslverr", 1'b0, er);
  endtask

  // Drive conditions and let them cross the synchroniser
  task automatic set_cond(input logic [17:0] c);
    @(posedge pclk);
    cond_raw <= c;
    repeat (6) @(posedge pclk);
  endtask

  task automatic pins(input logic on);
    repeat (2) @(posedge pclk);
    #1;
    chk1("load_input_on", on, load_input_on);
    chk1("load_input_hiz", !on, load_input_hiz);
  endtask

  // --------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------
  task automatic t_reset;
    pins(1'b0);
    rd(lsfr_pkg::ADDR_FAULT_SUM, 32'h0, "fault_summary_word");
    rd(lsfr_pkg::ADDR_OP_LO, 32'h1, "op_lo");
    rd(lsfr_pkg::ADDR_OP_HI, 32'h0, "op_hi");
    rd(lsfr_pkg::ADDR_LATCH_REL, 32'h0, "fault_latch_release");
    rd(lsfr_pkg::ADDR_IN_EN, 32'h0, "input_enable_flag");
    rd(lsfr_pkg::ADDR_START, 32'h0, "start");
  endtask

  // Each condition alone, read twice, then cleared and released
  task automatic t_map;
    logic [17:0] c;
    for (int i = 0; i < 18; i++)
    begin
      c = 18'h1 << i;
      set_cond(c);
      repeat (2)
      begin
        rd(lsfr_pkg::ADDR_FAULT_SUM, e_fs(c), "fsw");
        rd(lsfr_pkg::ADDR_OP_LO, e_lo(c, 1'b0), "op_lo");
        rd(lsfr_pkg::ADDR_OP_HI, e_hi(c, |c[3:0], |c[8:4]), "op_hi");
      end
      rd(lsfr_pkg::ADDR_LATCH_REL, {31'h0, |c[8:0]}, "latch");
      set_cond(18'h0);
      wr(lsfr_pkg::ADDR_LATCH_REL, 32'h1);
      rd(lsfr_pkg::ADDR_LATCH_REL, 32'h0, "latch");
      rd(lsfr_pkg::ADDR_OP_HI, 32'h0, "op_hi");
    end
  endtask

  task automatic t_start;
    wr(lsfr_pkg::ADDR_IN_EN, 32'h1);
    rd(lsfr_pkg::ADDR_IN_EN, 32'h1, "input_enable_flag");
    wr(lsfr_pkg::ADDR_START, 32'h1);
    pins(1'b1);
    rd(lsfr_pkg::ADDR_OP_LO, 32'h2, "op_lo");
    wr(lsfr_pkg::ADDR_IN_EN, 32'h0);
    pins(1'b0);
    wr(lsfr_pkg::ADDR_START, 32'h1);
    pins(1'b0);
    wr(lsfr_pkg::ADDR_IN_EN, 32'h1);
    wr(lsfr_pkg::ADDR_START, 32'h1);
    pins(1'b1);
  endtask

  // Fault while active, refused release, then proper recovery
  task automatic t_latch;
    set_cond(18'h1);
    pins(1'b0);
    wr(lsfr_pkg::ADDR_LATCH_REL, 32'h1);
    rd(lsfr_pkg::ADDR_LATCH_REL, 32'h1, "latch");
    rd(lsfr_pkg::ADDR_OP_HI, 32'h200, "op_hi");
    set_cond(18'h0);
    rd(lsfr_pkg::ADDR_LATCH_REL, 32'h1, "latch");
    wr(lsfr_pkg::ADDR_START, 32'h1);
    pins(1'b0);
    wr(lsfr_pkg::ADDR_LATCH_REL, 32'h1);
    pins(1'b0);
    rd(lsfr_pkg::ADDR_LATCH_REL, 32'h0, "latch");
    wr(lsfr_pkg::ADDR_START, 32'h1);
    pins(1'b1);
    set_cond(18'h20);
    pins(1'b0);
    rd(lsfr_pkg::ADDR_OP_HI, 32'h400, "op_hi");
  endtask

  task automatic t_bad;
    logic [31:0] d;
    logic er;
    host.xfer(1'b0, 16'h8000, 32'h0, d, er);
    chk1("pslverr", 1'b1, er);
    chk32("unmapped", 32'h0, d);
    host.xfer(1'b1, 16'h8000, 32'h1, d, er);
    chk1("pslverr", 1'b1, er);
    wr(lsfr_pkg::ADDR_FAULT_SUM, 32'hffff_ffff);
    rd(lsfr_pkg::ADDR_FAULT_SUM, e_fs(18'h20), "fsw");
  endtask

  // --------------------------------------------------------
  // Clock, reset, sequence, watchdog and verdict
  // --------------------------------------------------------
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Free running 50 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Reset for 16 cycles, then each scenario in turn
  initial
  begin
    err_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    cond_raw = 18'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_map;
    t_start;
    t_latch;
    t_bad;
    print_verdict;
  end

  // Cut a hang short
  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
